/* verilog/hisg_pkg.sv */
// Constants and types shared by the host request selector and pin port.
package hisg_pkg;

	localparam int HISG_DATA_W   = 16;
	localparam int HISG_BYTE_W   = 8;
	localparam int HISG_ADDR_W   = 3;
	localparam int HISG_PIN_N    = 4;
	localparam int HISG_REQ_N    = 4;
	localparam int HISG_ERR_N    = 6;
	localparam int HISG_FLAG_N   = 16;
	localparam int HISG_CODE_N   = 32;
	localparam int HISG_WIDE_W   = 5;
	localparam int HISG_NARROW_W = 4;
	localparam int HISG_WIDE_REQ = 2;
	localparam int HISG_EN_BIT   = 7;

	localparam logic [2:0] HISG_ADDR_DIR   = 3'h0;
	localparam logic [2:0] HISG_ADDR_VALUE = 3'h1;
	localparam logic [2:0] HISG_ADDR_REQ0  = 3'h2;
	localparam logic [2:0] HISG_ADDR_MASK  = 3'h6;

	localparam int HISG_CODE_NONE        = 0;
	localparam int HISG_CODE_IN_DONE     = 1;
	localparam int HISG_CODE_OUT_DONE    = 2;
	localparam int HISG_CODE_IN_SYNC     = 3;
	localparam int HISG_CODE_OUT_SYNC    = 4;
	localparam int HISG_CODE_IN_RTC_POS  = 5;
	localparam int HISG_CODE_IN_RTC_NEG  = 6;
	localparam int HISG_CODE_OUT_RTC_POS = 7;
	localparam int HISG_CODE_OUT_RTC_NEG = 8;
	localparam int HISG_CODE_PIN0_LOW    = 9;
	localparam int HISG_CODE_PIN1_LOW    = 10;
	localparam int HISG_CODE_ERR_OR      = 11;
	localparam int HISG_CODE_FIFO_BASE   = 16;

	localparam logic [31:0] HISG_VALID_WIDE   = 32'hFFFF0FFE;
	localparam logic [31:0] HISG_VALID_NARROW = 32'h00000FFE;

	localparam logic [3:0]  HISG_DIR_RST   = 4'h0;
	localparam logic [3:0]  HISG_VALUE_RST = 4'h0;
	localparam logic [7:0]  HISG_SEL_RST   = 8'h00;
	localparam logic [5:0]  HISG_MASK_RST  = 6'h00;
	localparam logic [15:0] HISG_RDATA_RST = 16'h0000;

	typedef logic [HISG_BYTE_W-1:0] hisg_byte_t;
	typedef logic [HISG_CODE_N-1:0] hisg_events_t;

endpackage : hisg_pkg

/* verilog/hisg_evt_if.sv */
// Event vector carried from the top to each request selector.
`timescale 1ns/1ps
interface hisg_evt_if;
	import hisg_pkg::*;

	hisg_events_t event_vec;

	modport src  (output event_vec);
	modport sink (input  event_vec);

endinterface : hisg_evt_if

/* verilog/hisg_pin_port.sv */
// Direction and value registers of the general purpose pin port.
`timescale 1ns/1ps
module hisg_pin_port
	import hisg_pkg::*;
#(
	parameter int PIN_N = HISG_PIN_N
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic             wr_dir,
	input  wire logic             wr_value,
	input  wire logic [PIN_N-1:0] wdata,
	output logic      [PIN_N-1:0] pin_dir,
	output logic      [PIN_N-1:0] pin_value
);

	logic [PIN_N-1:0] next_dir;
	logic [PIN_N-1:0] next_value;

	generate
		if (PIN_N != HISG_PIN_N) begin : g_bad
			$error("Pin count must match the register layout.");
		end
	endgenerate

	always_comb begin
		next_dir   = pin_dir;
		next_value = pin_value;
		if (wr_dir) begin
			next_dir = wdata; // RULE1
		end
		if (wr_value) begin
			next_value = wdata; // RULE4
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_dir   <= HISG_DIR_RST[PIN_N-1:0]; // RULE1
			pin_value <= HISG_VALUE_RST[PIN_N-1:0];
		end else if (ce) begin
			pin_dir   <= next_dir;
			pin_value <= next_value;
		end
	end

endmodule : hisg_pin_port

/* verilog/hisg_irq_sel.sv */
// One host request output with its enable bit and source selector.
`timescale 1ns/1ps
module hisg_irq_sel
	import hisg_pkg::*;
#(
	parameter int          SEL_W = HISG_WIDE_W,
	parameter logic [31:0] VALID = HISG_VALID_WIDE
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       ce,
	input  wire logic       wr,
	input  wire hisg_byte_t wdata,
	hisg_evt_if.sink        evt,
	output hisg_byte_t      sel_reg,
	output logic            irq,
	output logic            irq_oe
);

	logic             en;
	logic [SEL_W-1:0] code;
	logic             next_en;
	logic [SEL_W-1:0] next_code;
	logic             next_irq;
	logic [4:0]       idx;

	generate
		if (SEL_W != HISG_WIDE_W && SEL_W != HISG_NARROW_W) begin : g_bad
			$error("Source field must be four or five bits wide.");
		end
	endgenerate

	always_comb begin
		next_en   = en;
		next_code = code;
		if (wr) begin
			next_en   = wdata[HISG_EN_BIT]; // RULE6
			next_code = wdata[SEL_W-1:0]; // RULE8
		end
		idx = 5'h00;
		idx[SEL_W-1:0] = next_code;
		next_irq = next_en & VALID[idx] & evt.event_vec[idx]; // RULE7 RULE18 RULE20
		sel_reg = HISG_SEL_RST;
		sel_reg[HISG_EN_BIT] = en;
		sel_reg[SEL_W-1:0] = code; // RULE8
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			en     <= 1'b0; // RULE6
			code   <= HISG_SEL_RST[SEL_W-1:0]; // RULE10
			irq    <= 1'b0;
			irq_oe <= 1'b0;
		end else if (ce) begin
			en     <= next_en;
			code   <= next_code;
			irq    <= next_irq;
			irq_oe <= next_en; // RULE6
		end
	end

endmodule : hisg_irq_sel

/* verilog/hisg_top.sv */
// Host request routing and general purpose pin port, host register side.
//
// Operation
// RULE1: Each pin has a direction bit; zero means input; reset clears all.
// RULE2: With direction one, the pin is driven from its value bit.
// RULE3: Reading the value register returns present pin levels.
// RULE4: Value writes to input pins are stored and appear once output.
// RULE5: Pin registers use bits 3 to 0 of the low byte; rest zero.
// RULE6: Bit 7 enables each request; disabled requests are not driven.
// RULE7: An enabled request signals the event its source field selects.
// RULE8: Requests 0,1 have 5-bit fields, 2,3 have 4-bit; reset zero.
// RULE9: Wide selectors offer 27 sources, narrow selectors offer 11.
// RULE10: Code zero selects no event and is the reset default.
// RULE11: Codes 1 and 2 select input and output one-pass completion.
// RULE12: Codes 3 and 4 select input and output synchronisation seen.
// RULE13: Codes 5 to 8 select both retrigger controllers, both polarities.
// RULE14: Codes 9 and 10 raise the request while pin 0 or 1 is low.
// RULE15: Code 11 selects the OR of unmasked error conditions.
// RULE16: Codes 16 to 20 select first input FIFO flags, second full.
// RULE17: Codes 21 to 31 select remaining input and both output FIFO flags.
// RULE18: Unassigned codes are reserved and raise nothing.
// RULE19: Narrow codes 0 to 11 mean the same as the wide codes.
// RULE20: Enabled requests follow the selected level through one register.
`timescale 1ns/1ps
module hisg_top
	import hisg_pkg::*;
#(
	parameter int PIN_N = HISG_PIN_N,
	parameter int ERR_N = HISG_ERR_N
) (
	input  wire logic                   CLK,
	input  wire logic                   RESET,
	input  wire logic                   CE,
	input  wire logic [HISG_ADDR_W-1:0] HOST_ADDR,
	input  wire logic                   HOST_WR,
	input  wire logic                   HOST_RD,
	input  wire logic [HISG_DATA_W-1:0] HOST_WDATA,
	output logic      [HISG_DATA_W-1:0] HOST_RDATA,
	input  wire logic [PIN_N-1:0]       GPIO_IN,
	output logic      [PIN_N-1:0]       GPIO_OUT,
	output logic      [PIN_N-1:0]       GPIO_OE,
	input  wire logic                   IN_ACQ_DONE,
	input  wire logic                   OUT_ACQ_DONE,
	input  wire logic                   IN_SYNC_SEEN,
	input  wire logic                   OUT_SYNC_SEEN,
	input  wire logic                   IN_RETRIG,
	input  wire logic                   OUT_RETRIG,
	input  wire logic [HISG_FLAG_N-1:0] FIFO_FLAGS,
	input  wire logic [ERR_N-1:0]       ERR_STATUS,
	output logic      [HISG_REQ_N-1:0]  IRQ_OUT,
	output logic      [HISG_REQ_N-1:0]  IRQ_OE
);

	logic [ERR_N-1:0]       error_mask;
	logic [ERR_N-1:0]       next_error_mask;
	logic [HISG_DATA_W-1:0] next_rdata;
	logic                   err_any;
	logic                   wr_dir;
	logic                   wr_value;
	logic                   wr_mask;
	logic [HISG_REQ_N-1:0]  wr_req;
	hisg_byte_t             sel_rd [HISG_REQ_N];
	logic [PIN_N-1:0]       pin_dir;
	logic [PIN_N-1:0]       pin_value;

	hisg_evt_if evt ();

	generate
		if (PIN_N != HISG_PIN_N) begin : g_bad_pins
			$error("Pin count must be four.");
		end
		if (ERR_N != HISG_ERR_N) begin : g_bad_err
			$error("Error condition count must be six.");
		end
	endgenerate

	// Host write decode; unmapped addresses are ignored.
	always_comb begin
		wr_dir   = HOST_WR && (HOST_ADDR == HISG_ADDR_DIR);
		wr_value = HOST_WR && (HOST_ADDR == HISG_ADDR_VALUE);
		wr_mask  = HOST_WR && (HOST_ADDR == HISG_ADDR_MASK);
		for (int i = 0; i < HISG_REQ_N; i++) begin
			wr_req[i] = HOST_WR &&
				(HOST_ADDR == (HISG_ADDR_REQ0 + 3'(i)));
		end
	end

	// Error interrupt mask register.
	always_comb begin
		next_error_mask = error_mask;
		if (wr_mask) begin
			next_error_mask = HOST_WDATA[ERR_N-1:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			error_mask <= HISG_MASK_RST[ERR_N-1:0];
		end else if (CE) begin
			error_mask <= next_error_mask;
		end
	end

	// Event vector indexed by source code.
	always_comb begin
		err_any = |(ERR_STATUS & error_mask); // RULE15
		evt.event_vec = '0;
		evt.event_vec[HISG_CODE_NONE]        = 1'b0; // RULE10
		evt.event_vec[HISG_CODE_IN_DONE]     = IN_ACQ_DONE; // RULE11
		evt.event_vec[HISG_CODE_OUT_DONE]    = OUT_ACQ_DONE; // RULE11
		evt.event_vec[HISG_CODE_IN_SYNC]     = IN_SYNC_SEEN; // RULE12
		evt.event_vec[HISG_CODE_OUT_SYNC]    = OUT_SYNC_SEEN; // RULE12
		evt.event_vec[HISG_CODE_IN_RTC_POS]  = IN_RETRIG; // RULE13
		evt.event_vec[HISG_CODE_IN_RTC_NEG]  = ~IN_RETRIG; // RULE13
		evt.event_vec[HISG_CODE_OUT_RTC_POS] = OUT_RETRIG; // RULE13
		evt.event_vec[HISG_CODE_OUT_RTC_NEG] = ~OUT_RETRIG; // RULE13
		evt.event_vec[HISG_CODE_PIN0_LOW]    = ~GPIO_IN[0]; // RULE14
		evt.event_vec[HISG_CODE_PIN1_LOW]    = ~GPIO_IN[1]; // RULE14
		evt.event_vec[HISG_CODE_ERR_OR]      = err_any; // RULE15
		// Flags in order: full, almost full, empty, almost empty.
		evt.event_vec[HISG_CODE_FIFO_BASE +: HISG_FLAG_N] =
			FIFO_FLAGS; // RULE16 RULE17
	end

	hisg_pin_port #(
		.PIN_N (PIN_N)
	) u_pins (
		.clk       (CLK),
		.reset     (RESET),
		.ce        (CE),
		.wr_dir    (wr_dir),
		.wr_value  (wr_value),
		.wdata     (HOST_WDATA[PIN_N-1:0]),
		.pin_dir   (pin_dir),
		.pin_value (pin_value)
	);

	// Value and direction registers drive the pins straight from flops.
	always_comb begin
		GPIO_OUT = pin_value; // RULE2 RULE4
		GPIO_OE  = pin_dir; // RULE2
	end

	genvar g;
	generate
		for (g = 0; g < HISG_REQ_N; g++) begin : g_req
			localparam int          SW = (g < HISG_WIDE_REQ) ?
				HISG_WIDE_W : HISG_NARROW_W; // RULE8
			localparam logic [31:0] VM = (g < HISG_WIDE_REQ) ?
				HISG_VALID_WIDE : HISG_VALID_NARROW; // RULE9 RULE19
			hisg_irq_sel #(
				.SEL_W (SW),
				.VALID (VM)
			) u_sel (
				.clk     (CLK),
				.reset   (RESET),
				.ce      (CE),
				.wr      (wr_req[g]),
				.wdata   (HOST_WDATA[HISG_BYTE_W-1:0]),
				.evt     (evt.sink),
				.sel_reg (sel_rd[g]),
				.irq     (IRQ_OUT[g]),
				.irq_oe  (IRQ_OE[g])
			);
		end
	endgenerate

	// Host read data, registered and held until the next read.
	always_comb begin
		next_rdata = HOST_RDATA;
		if (HOST_RD) begin
			next_rdata = HISG_RDATA_RST;
			case (HOST_ADDR)
				HISG_ADDR_DIR: begin
					next_rdata[PIN_N-1:0] = pin_dir; // RULE5
				end
				HISG_ADDR_VALUE: begin
					next_rdata[PIN_N-1:0] = GPIO_IN; // RULE3 RULE5
				end
				HISG_ADDR_MASK: begin
					next_rdata[ERR_N-1:0] = error_mask;
				end
				default: begin
					for (int i = 0; i < HISG_REQ_N; i++) begin
						if (HOST_ADDR == (HISG_ADDR_REQ0 + 3'(i))) begin
							next_rdata[HISG_BYTE_W-1:0] = sel_rd[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			HOST_RDATA <= HISG_RDATA_RST;
		end else if (CE) begin
			HOST_RDATA <= next_rdata;
		end
	end

endmodule : hisg_top

/* tb/hisg_top_asserts.sv */
// Port-level checks of the request selector and pin port.
`timescale 1ns/1ps
module hisg_top_asserts
	import hisg_pkg::*;
#(
	parameter int PIN_N = HISG_PIN_N
) (
	input wire logic                   CLK,
	input wire logic                   RESET,
	input wire logic                   CE,
	input wire logic [HISG_ADDR_W-1:0] HOST_ADDR,
	input wire logic                   HOST_WR,
	input wire logic                   HOST_RD,
	input wire logic [HISG_DATA_W-1:0] HOST_WDATA,
	input wire logic [HISG_DATA_W-1:0] HOST_RDATA,
	input wire logic [PIN_N-1:0]       GPIO_IN,
	input wire logic [PIN_N-1:0]       GPIO_OUT,
	input wire logic [PIN_N-1:0]       GPIO_OE,
	input wire logic [HISG_REQ_N-1:0]  IRQ_OUT,
	input wire logic [HISG_REQ_N-1:0]  IRQ_OE
);
	logic wr_ok;
	logic rd_ok;
	assign wr_ok = CE && HOST_WR;
	assign rd_ok = CE && HOST_RD;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	property p_dir_write;
		wr_ok && HOST_ADDR == HISG_ADDR_DIR
		|=> GPIO_OE == $past(HOST_WDATA[PIN_N-1:0]);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("direction write not applied");
	property p_val_write;
		wr_ok && HOST_ADDR == HISG_ADDR_VALUE
		|=> GPIO_OUT == $past(HOST_WDATA[PIN_N-1:0]) && $stable(GPIO_OE);
	endproperty
	a_val_write: assert property (p_val_write)
		else $error("value write not stored");
	property p_out_hold;
		!(wr_ok && HOST_ADDR == HISG_ADDR_VALUE) |=> $stable(GPIO_OUT);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("pin drive changed without a write");
	property p_reset;
		$fell(RESET) |-> GPIO_OE == '0 && GPIO_OUT == '0
			&& IRQ_OE == '0 && IRQ_OUT == '0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not cleared by reset");
	property p_rd_pins;
		rd_ok && HOST_ADDR == HISG_ADDR_VALUE
		|=> HOST_RDATA[PIN_N-1:0] == $past(GPIO_IN);
	endproperty
	a_rd_pins: assert property (p_rd_pins)
		else $error("value read not the pin levels");
	property p_rd_high;
		rd_ok && HOST_ADDR <= HISG_ADDR_VALUE |=> HOST_RDATA[15:PIN_N] == '0;
	endproperty
	a_rd_high: assert property (p_rd_high)
		else $error("pin register upper bits not zero");
	property p_en_write;
		wr_ok && HOST_ADDR == HISG_ADDR_REQ0
		|=> IRQ_OE[0] == $past(HOST_WDATA[HISG_EN_BIT]);
	endproperty
	a_en_write: assert property (p_en_write)
		else $error("request enable not applied");
	property p_tristate;
		(IRQ_OUT & ~IRQ_OE) == '0;
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("disabled request is active");
	property p_freeze;
		!CE |=> $stable(IRQ_OUT) && $stable(IRQ_OE);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("request moved with clock enable low");
endmodule : hisg_top_asserts

bind hisg_top hisg_top_asserts #(.PIN_N(PIN_N)) u_asserts (.CLK, .RESET,
	.CE, .HOST_ADDR, .HOST_WR, .HOST_RD, .HOST_WDATA, .HOST_RDATA,
	.GPIO_IN, .GPIO_OUT, .GPIO_OE, .IRQ_OUT, .IRQ_OE);

/* tb/hisg_pin_model.sv */
// External pin drivers with pull-ups on the four port pins.
`timescale 1ns/1ps
module hisg_pin_model
	import hisg_pkg::*;
(
	input  wire logic [HISG_PIN_N-1:0] dev_val,
	input  wire logic [HISG_PIN_N-1:0] dev_oe,
	input  wire logic [HISG_PIN_N-1:0] ext_val,
	input  wire logic [HISG_PIN_N-1:0] ext_oe,
	output logic      [HISG_PIN_N-1:0] pins
);
	always_comb begin
		for (int i = 0; i < HISG_PIN_N; i++) begin
			if (dev_oe[i])
				pins[i] = dev_val[i];
			else if (ext_oe[i])
				pins[i] = ext_val[i];
			else
				pins[i] = 1'b1;
		end
	end
endmodule : hisg_pin_model

/* tb/hisg_top_tb.sv */
// Self-checking bench for the request selector and pin port.
`timescale 1ns/1ps
module hisg_top_tb
	import hisg_pkg::*;
;
	logic        clk, reset, ce, wr, rd;
	logic [2:0]  addr;
	logic [15:0] wdata, rdata;
	logic [3:0]  pins, gpio_out, gpio_oe, ext_val, ext_oe, irq_out, irq_oe;
	logic [31:0] stim;
	int          err_count, n_tests, cc;
	hisg_top uut (.CLK(clk), .RESET(reset), .CE(ce), .HOST_ADDR(addr),
		.HOST_WR(wr), .HOST_RD(rd), .HOST_WDATA(wdata), .HOST_RDATA(rdata),
		.GPIO_IN(pins), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe),
		.IN_ACQ_DONE(stim[0]), .OUT_ACQ_DONE(stim[1]),
		.IN_SYNC_SEEN(stim[2]), .OUT_SYNC_SEEN(stim[3]),
		.IN_RETRIG(stim[4]), .OUT_RETRIG(stim[5]),
		.FIFO_FLAGS(stim[31:16]), .ERR_STATUS(stim[11:6]),
		.IRQ_OUT(irq_out), .IRQ_OE(irq_oe));
	hisg_pin_model u_pins (.dev_val(gpio_out), .dev_oe(gpio_oe),
		.ext_val(ext_val), .ext_oe(ext_oe), .pins(pins));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [2:0] a, input logic [15:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		check(rdata, exp);
	endtask : rd_reg
	task automatic end_test(input string name);
		$display("test %s ended, mismatches %0d", name, err_count);
	endtask : end_test
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	function automatic logic exp_src(input int c, input bit wide);
		logic [11:0] ev;
		ev = {|(stim[11:6] & 6'h05), ~pins[1], ~pins[0], ~stim[5], stim[5],
			~stim[4], stim[4], stim[3:0], 1'b0};
		if (c < 12)
			return ev[c];
		return (wide && c >= 16) ? stim[c] : 1'b0;
	endfunction : exp_src
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 16'h0000;
		stim = 32'h0000_0000;
		ext_val = 4'h0;
		ext_oe = 4'h0;
		err_count = 0;
		n_tests = 0;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		for (int a = 0; a < 8; a++)
			rd_reg(3'(a), a == 1 ? 16'h000F : 16'h0000);
		check({4'h0, gpio_oe, irq_oe, irq_out}, 16'h0000);
		end_test("reset");
		wr_reg(HISG_ADDR_VALUE, 16'hFF5A);
		rd_reg(HISG_ADDR_VALUE, 16'h000F);
		check({12'h000, gpio_out}, 16'h000A);
		wr_reg(HISG_ADDR_DIR, 16'hFFF3);
		rd_reg(HISG_ADDR_DIR, 16'h0003);
		rd_reg(HISG_ADDR_VALUE, 16'h000E);
		ext_oe = 4'h4;
		rd_reg(HISG_ADDR_VALUE, 16'h000A);
		wr_reg(HISG_ADDR_VALUE, 16'h0005);
		rd_reg(HISG_ADDR_VALUE, 16'h0009);
		end_test("pins");
		wr_reg(HISG_ADDR_MASK, 16'hFFC5);
		rd_reg(HISG_ADDR_MASK, 16'h0005);
		for (int r = 0; r < 4; r++) begin
			for (int p = 0; p < 2; p++) begin
				stim = p ? 32'hAAAA_F56A : 32'h5555_0A95;
				wr_reg(HISG_ADDR_VALUE, p ? 16'h0006 : 16'h0005);
				for (int c = 0; c < 32; c++) begin
					cc = r < 2 ? c : c % 16;
					wr_reg(HISG_ADDR_REQ0 + 3'(r), {8'hFF, 3'h7, 5'(c)});
					check({14'h0, irq_oe[r], irq_out[r]},
						{14'h0, 1'b1, exp_src(cc, r < 2)});
					rd_reg(HISG_ADDR_REQ0 + 3'(r), 16'h0080 | 16'(cc));
				end
			end
			wr_reg(HISG_ADDR_REQ0 + 3'(r), 16'h000A);
			check({14'h0, irq_oe[r], irq_out[r]}, 16'h0000);
		end
		end_test("requests");
		wr_reg(HISG_ADDR_REQ0, 16'h0081);
		ce = 1'b0;
		stim[0] = 1'b1;
		wr_reg(HISG_ADDR_DIR, 16'h0000);
		check({11'h0, gpio_oe, irq_out[0]}, 16'h0006);
		ce = 1'b1;
		@(negedge clk);
		check({15'h0, irq_out[0]}, 16'h0001);
		wr_reg(3'h7, 16'h00FF);
		rd_reg(3'h7, 16'h0000);
		end_test("freeze");
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		rd_reg(HISG_ADDR_DIR, 16'h0000);
		check({4'h0, gpio_oe, irq_oe, irq_out}, 16'h0000);
		end_test("second reset");
		print_verdict();
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		print_verdict();
	end
endmodule : hisg_top_tb
